/* File: core/reset_timer_and_watchdog.v */
/*
 * Reset timer and watchdog top: power-on latch, reset delay counter,
 * watchdog, reset cause flags and an AXI4-Lite register slave.
 * Assumes one 125 MHz aclk; configuration bits are static straps and the
 * wake events and core instructions arrive as aclk pulses.
 */
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "reset_watchdog_regs.vh"

module reset_timer_and_watchdog #(
	parameter integer POR_CYCLES = `POR_DELAY_MS * `CLK_MHZ * 1000,
	parameter integer WDT_PERIOD_TICKS = `WDT_PERIOD_MS * `CLK_MHZ * 1000 / `WDT_OSC_DIV,
	parameter integer WDT_OSC_DIV = `WDT_OSC_DIV
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] awaddr,
	input wire [2:0] awprot,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [7:0] araddr,
	input wire [2:0] arprot,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire shared_input_pin,
	input wire master_clear_select_cfg,
	input wire watchdog_enable_cfg,
	input wire pin_wake_event,
	input wire comparator_wake_event,
	output reg core_reset,
	output reg sleep_active
);
	localparam integer SHORT_CYCLES = `SHORT_DELAY_US * `CLK_MHZ;
	localparam CNT_W = 22;
	localparam PER_W = 15;

	// Pin synchroniser
	reg pin_meta;
	reg pin_sync;

	// Register state
	reg [7:0] timer_prescale_options;
	reg timeout_flag;
	reg power_down_flag;
	reg pin_wake_flag;
	reg comparator_wake_flag;
	reg wdt_clear_req;
	reg sleep_req;
	reg power_on_pending;

	// Write channel holding state
	reg aw_got;
	reg w_got;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire delay_active;
	wire wdt_timeout;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			pin_meta <= shared_input_pin;
			pin_sync <= pin_meta;
		end
	end

	// Master clear is inactive when the pin serves as general input
	wire clear_high = !master_clear_select_cfg || pin_sync;
	wire wdt_en = watchdog_enable_cfg;
	wire master_clear_evt = !clear_high;
	wire wdt_evt = wdt_timeout && wdt_en && !core_reset && !delay_active;
	wire pin_evt = pin_wake_event && sleep_active && !core_reset;
	wire cmp_evt = comparator_wake_event && sleep_active && !core_reset;
	wire any_evt = master_clear_evt || wdt_evt || pin_evt || cmp_evt;
	wire do_sleep = sleep_req && !core_reset && !sleep_active;
	wire do_clear = wdt_clear_req && !core_reset;
	wire wdt_clear = do_clear || do_sleep || any_evt || core_reset;
	wire keep_long = power_on_pending && delay_active;

	// Master clear held low at power-up restarts the delay, which must stay long
	always @(posedge aclk) begin
		if (!aresetn) begin
			power_on_pending <= 1'b1;
		end else if (!delay_active) begin
			power_on_pending <= 1'b0;
		end
	end

	reset_delay_timer #(
		.CNT_W(CNT_W),
		.LONG_CYCLES(POR_CYCLES),
		.SHORT_CYCLES(SHORT_CYCLES)
	) u_delay (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(any_evt),
		.use_long(keep_long),
		.run_ok(clear_high),
		.active(delay_active)
	);

	watchdog_core #(
		.PER_W(PER_W),
		.PERIOD_TICKS(WDT_PERIOD_TICKS),
		.OSC_DIV(WDT_OSC_DIV)
	) u_wdt (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(wdt_en),
		.clear(wdt_clear),
		.assign_wdt(timer_prescale_options[`OPT_ASSIGN_BIT]),
		.rate(timer_prescale_options[`OPT_RATE_MSB:`OPT_RATE_LSB]),
		.timeout(wdt_timeout)
	);

	// Core reset and sleep state
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_reset <= 1'b1;
			sleep_active <= 1'b0;
		end else begin
			core_reset <= delay_active || any_evt;
			if (any_evt) begin
				sleep_active <= 1'b0;
			end else if (do_sleep) begin
				sleep_active <= 1'b1;
			end
		end
	end

	// Reset cause flags; hardware events and the sleep instruction touch them
	always @(posedge aclk) begin
		if (!aresetn) begin
			timeout_flag <= 1'b1;
			power_down_flag <= 1'b1;
			pin_wake_flag <= 1'b0;
			comparator_wake_flag <= 1'b0;
		end else if (master_clear_evt) begin
			pin_wake_flag <= 1'b0;
			comparator_wake_flag <= 1'b0;
			if (sleep_active) begin
				timeout_flag <= 1'b1;
				power_down_flag <= 1'b0;
			end
		end else if (wdt_evt) begin
			timeout_flag <= 1'b0;
			pin_wake_flag <= 1'b0;
			comparator_wake_flag <= 1'b0;
			if (sleep_active) begin
				power_down_flag <= 1'b0;
			end
		end else if (pin_evt) begin
			pin_wake_flag <= 1'b1;
			comparator_wake_flag <= 1'b0;
			timeout_flag <= 1'b1;
			power_down_flag <= 1'b0;
		end else if (cmp_evt) begin
			comparator_wake_flag <= 1'b1;
			pin_wake_flag <= 1'b0;
			timeout_flag <= 1'b1;
			power_down_flag <= 1'b0;
		end else if (do_sleep) begin
			timeout_flag <= 1'b1;
			power_down_flag <= 1'b0;
		end
	end

	// AXI4-Lite write path
	wire do_write = aw_got && w_got && !bvalid;
	wire [7:0] aw_word = {aw_addr[7:2], 2'h0};
	wire wr_options = aw_word == `OFS_OPTIONS;
	wire wr_status = aw_word == `OFS_STATUS;
	wire wr_control = aw_word == `OFS_CONTROL;
	wire wr_mapped = wr_options || wr_status || wr_control;

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_addr <= awaddr;
				aw_got <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
				w_got <= 1'b1;
				wready <= 1'b0;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
				aw_got <= 1'b0;
				w_got <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Options and instruction pulses; options return to all ones on every reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			timer_prescale_options <= `OPTIONS_RESET;
			wdt_clear_req <= 1'b0;
			sleep_req <= 1'b0;
		end else begin
			wdt_clear_req <= 1'b0;
			sleep_req <= 1'b0;
			if (any_evt) begin
				timer_prescale_options <= `OPTIONS_RESET;
			end else if (do_write && wr_options && w_strb[0]) begin
				timer_prescale_options <= w_data[7:0];
			end
			if (do_write && wr_control && w_strb[0]) begin
				wdt_clear_req <= w_data[`CTL_WDT_CLEAR_BIT];
				sleep_req <= w_data[`CTL_SLEEP_BIT];
			end
		end
	end

	// AXI4-Lite read path; options read as zero, being write-only
	wire [7:0] ar_word = {araddr[7:2], 2'h0};
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;

	always @* begin
		next_rdata = 32'h0000_0000;
		next_rresp = `RESP_OKAY;
		case (ar_word)
			`OFS_OPTIONS: begin
				next_rdata = 32'h0000_0000;
			end
			`OFS_STATUS: begin
				next_rdata[`ST_PIN_WAKE_BIT] = pin_wake_flag;
				next_rdata[`ST_CMP_WAKE_BIT] = comparator_wake_flag;
				next_rdata[`ST_TIMEOUT_BIT] = timeout_flag;
				next_rdata[`ST_PDOWN_BIT] = power_down_flag;
				next_rdata[`ST_WDT_EN_BIT] = wdt_en;
				next_rdata[`ST_SLEEP_BIT] = sleep_active;
				next_rdata[`ST_CORE_RST_BIT] = core_reset;
			end
			`OFS_CONTROL: begin
				next_rdata = 32'h0000_0000;
			end
			default: begin
				next_rresp = `RESP_SLVERR;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= next_rdata;
				rresp <= next_rresp;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule // reset_timer_and_watchdog

`default_nettype wire

/* File: core/reset_watchdog_regs.vh */
/*
 * Register map, field positions, reset values and timing figures of the
 * reset timer and watchdog block. Assumes the includer uses a 125 MHz aclk.
 */
`ifndef RESET_WATCHDOG_REGS_VH
`define RESET_WATCHDOG_REGS_VH

`define OFS_OPTIONS 8'h00
`define OFS_STATUS 8'h04
`define OFS_CONTROL 8'h08

`define OPTIONS_RESET 8'hFF
`define OPT_ASSIGN_BIT 3
`define OPT_RATE_MSB 2
`define OPT_RATE_LSB 0

`define ST_PIN_WAKE_BIT 7
`define ST_CMP_WAKE_BIT 6
`define ST_TIMEOUT_BIT 4
`define ST_PDOWN_BIT 3
`define ST_WDT_EN_BIT 2
`define ST_SLEEP_BIT 1
`define ST_CORE_RST_BIT 0

`define CTL_WDT_CLEAR_BIT 0
`define CTL_SLEEP_BIT 1

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_MHZ 125
`define POR_DELAY_MS 18
`define SHORT_DELAY_US 10
`define WDT_PERIOD_MS 18
`define WDT_OSC_DIV 125

`endif

/* File: core/reset_delay_timer.v */
/*
 * Reset delay counter: holds its active output while counting a long or a
 * short delay. Assumes start is an aclk pulse or level (held to keep restarting) and run_ok a
 * synchronised level.
 */
`timescale 1ns/1ns
`default_nettype none

module reset_delay_timer #(
	parameter CNT_W = 22,
	parameter integer LONG_CYCLES = 2250000,
	parameter integer SHORT_CYCLES = 1250
) (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire use_long,
	input wire run_ok,
	output reg active
);
	localparam integer LONG_M1 = LONG_CYCLES - 1;
	localparam integer SHORT_M1 = SHORT_CYCLES - 1;
	localparam [CNT_W-1:0] LONG_LAST = LONG_M1[CNT_W-1:0];
	localparam [CNT_W-1:0] SHORT_LAST = SHORT_M1[CNT_W-1:0];

	reg [CNT_W-1:0] cnt;
	reg long_sel;
	wire [CNT_W-1:0] last = long_sel ? LONG_LAST : SHORT_LAST;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= {CNT_W{1'b0}};
			active <= 1'b1;
			long_sel <= 1'b1;
		end else if (start) begin
			cnt <= {CNT_W{1'b0}};
			active <= 1'b1;
			long_sel <= use_long;
		end else if (active && run_ok) begin
			cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
			if (cnt == last) begin
				active <= 1'b0;
			end
		end
	end
endmodule // reset_delay_timer

`default_nettype wire

/* File: core/watchdog_core.v */
/*
 * Watchdog counter with its own free-running oscillator tick and an
 * optional power-of-two prescaler. Assumes all inputs are on aclk.
 */
`timescale 1ns/1ns
`default_nettype none

module watchdog_core #(
	parameter PER_W = 15,
	parameter integer PERIOD_TICKS = 18000,
	parameter integer OSC_DIV = 125
) (
	input wire aclk,
	input wire aresetn,
	input wire enable,
	input wire clear,
	input wire assign_wdt,
	input wire [2:0] rate,
	output reg timeout
);
	localparam integer OSC_M1 = OSC_DIV - 1;
	localparam integer PER_M1 = PERIOD_TICKS - 1;
	localparam [7:0] OSC_LAST = OSC_M1[7:0];
	localparam [PER_W-1:0] PER_LAST = PER_M1[PER_W-1:0];

	reg [7:0] osc_cnt;
	reg osc_tick;
	reg [6:0] pre_cnt;
	reg [PER_W-1:0] cnt;
	wire [6:0] mask = ~(7'h7F << rate);
	wire count_en = osc_tick && (!assign_wdt || ((pre_cnt & mask) == mask));

	// Oscillator never stops or clears, so sleep does not halt it
	always @(posedge aclk) begin
		if (!aresetn) begin
			osc_cnt <= 8'h00;
			osc_tick <= 1'b0;
		end else begin
			osc_tick <= (osc_cnt == OSC_LAST);
			osc_cnt <= (osc_cnt == OSC_LAST) ? 8'h00 : osc_cnt + 8'h01;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pre_cnt <= 7'h00;
			cnt <= {PER_W{1'b0}};
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (clear) begin
				cnt <= {PER_W{1'b0}};
				if (assign_wdt) begin
					pre_cnt <= 7'h00;
				end
			end else if (!enable) begin
				cnt <= {PER_W{1'b0}};
			end else begin
				if (osc_tick && assign_wdt) begin
					pre_cnt <= pre_cnt + 7'h01;
				end
				if (count_en) begin
					if (cnt == PER_LAST) begin
						cnt <= {PER_W{1'b0}};
						timeout <= 1'b1;
					end else begin
						cnt <= cnt + {{(PER_W-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	end
endmodule // watchdog_core

`default_nettype wire

/* File: test/rtw_checker_asserts.sv */
/*
 * Port-level assertions for reset_timer_and_watchdog.
 * Assumes a 125 MHz aclk and straps that change only while aresetn is low.
 */
`timescale 1ns/1ns
`default_nettype none
module rtw_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic shared_input_pin,
	input wire logic master_clear_select_cfg,
	input wire logic watchdog_enable_cfg,
	input wire logic pin_wake_event,
	input wire logic comparator_wake_event,
	input wire logic core_reset,
	input wire logic sleep_active
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_reset_latch: assert property ($rose(aresetn) |-> core_reset)
		else $error("core left reset at power-up");
	a_pin_holds: assert property ((master_clear_select_cfg && !shared_input_pin) [*4] |=> core_reset)
		else $error("master clear low without core reset");
	a_wake_reset: assert property (sleep_active && !core_reset && (pin_wake_event || comparator_wake_event)
		|=> core_reset)
		else $error("wake event gave no reset");
	// Pin history covers the two synchroniser flops
	a_wdt_off: assert property (!watchdog_enable_cfg && !core_reset && !sleep_active &&
		(!master_clear_select_cfg || shared_input_pin && $past(shared_input_pin) && $past(shared_input_pin, 2)
		&& $past(shared_input_pin, 3)) |=> !core_reset)
		else $error("reset with watchdog disabled");
	a_write_resp: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_write_busy: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	a_read_next: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read data late");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
endmodule // rtw_checker
bind reset_timer_and_watchdog rtw_checker i_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.shared_input_pin(shared_input_pin), .master_clear_select_cfg(master_clear_select_cfg),
	.watchdog_enable_cfg(watchdog_enable_cfg), .pin_wake_event(pin_wake_event),
	.comparator_wake_event(comparator_wake_event), .core_reset(core_reset), .sleep_active(sleep_active));
`default_nettype wire

/* File: test/core_model.sv */
/*
 * Processor core model: issues register writes and reads as an AXI4-Lite master.
 * Assumes one transfer at a time; raises hung when the slave never answers.
 */
`timescale 1ns/1ns
`default_nettype none
module core_model (
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready,
	output logic hung
);
	// Late ready makes the slave hold its answer for a cycle
	logic late_ready = 1'b0;
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, hung} = '0;
	end
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !late_ready;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bready && bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			if (bvalid)
				bready <= 1'b1;
		end
		if (n >= 200)
			hung <= 1'b1;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		d = 32'hFFFF_FFFF;
		r = 2'h3;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !late_ready;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rready && rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
			if (rvalid)
				rready <= 1'b1;
		end
		if (n >= 200)
			hung <= 1'b1;
	endtask
endmodule // core_model
`default_nettype wire

/* File: test/reset_timer_and_watchdog_tb.sv */
/*
 * Self-checking bench for reset_timer_and_watchdog with shortened counts.
 * Assumes core_model as bus master and the register header on the path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "reset_watchdog_regs.vh"
module reset_timer_and_watchdog_tb;
	localparam int POR = 200;
	localparam int PER = 80;
	logic aclk, aresetn, pin, msel, wen, pwake, cwake, hung;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, core_reset, sleep_active;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	int failures = 0;
	int comparisons = 0;
	int n;
	logic [1:0] r;
	logic [31:0] d;
	initial begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end
	initial {aresetn, pin, msel, wen, pwake, cwake} = 6'b000000;
	// Period is 20 ticks of 4 cycles
	reset_timer_and_watchdog #(.POR_CYCLES(POR), .WDT_PERIOD_TICKS(20), .WDT_OSC_DIV(4)) i_dut (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .shared_input_pin(pin), .master_clear_select_cfg(msel),
		.watchdog_enable_cfg(wen), .pin_wake_event(pwake), .comparator_wake_event(cwake),
		.core_reset(core_reset), .sleep_active(sleep_active));
	core_model i_core (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.hung(hung));
	task test_done;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	always @(posedge hung) begin
		failures++;
		test_done;
	end
	task w(input logic [7:0] a, input logic [31:0] v);
		i_core.wr(a, v, r);
		check("bresp", r, `RESP_OKAY);
	endtask
	task rs(input logic [31:0] exp);
		i_core.rd(`OFS_STATUS, d, r);
		check("status", d, exp);
	endtask
	task wait_rst(input logic lvl);
		for (n = 0; core_reset !== lvl; n++) begin
			@(posedge aclk);
			if (n > 20000) begin
				failures++;
				test_done;
			end
		end
	endtask
	task por(input logic e, input logic m);
		@(posedge aclk);
		aresetn <= 1'b0;
		wen <= e;
		msel <= m;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task t_por;
		por(1'b1, 1'b1);
		repeat (POR + 40) @(posedge aclk);
		check("held", core_reset, 1);
		pin <= 1'b1;
		wait_rst(1'b0);
		check("por_len", n >= POR && n <= POR + 5, 1);
		rs(32'h1C);
		i_core.late_ready <= 1'b1;
		i_core.wr(8'h0C, 32'h0, r);
		check("bad_wr", r, `RESP_SLVERR);
		i_core.rd(8'h10, d, r);
		check("bad_rd", r, `RESP_SLVERR);
		i_core.late_ready <= 1'b0;
		i_core.rd(`OFS_OPTIONS, d, r);
		check("opt_rd", d, 0);
	endtask
	task t_wdt;
		int e;
		for (int i = 0; i < 9; i++) begin
			w(`OFS_OPTIONS, i < 8 ? 8 | i : 7);
			w(`OFS_CONTROL, 1);
			wait_rst(1'b1);
			e = i < 8 ? PER << i : PER;
			check("wdt_len", n + 8 >= e && n <= e + 8, 1);
			wait_rst(1'b0);
			check("short", n >= 1250 && n <= 1256, 1);
			rs(32'h0C);
		end
	endtask
	task t_sleep;
		w(`OFS_OPTIONS, 0);
		repeat (5) begin
			repeat (40) @(posedge aclk);
			w(`OFS_CONTROL, 1);
			check("kept", core_reset, 0);
		end
		w(`OFS_CONTROL, 2);
		rs(32'h16);
		wait_rst(1'b1);
		check("sleep_len", n + 16 >= PER && n <= PER + 8, 1);
		wait_rst(1'b0);
		rs(32'h04);
	endtask
	task t_wake;
		logic [31:0] exp [3] = '{32'h94, 32'h54, 32'h14};
		for (int k = 0; k < 3; k++) begin
			w(`OFS_CONTROL, 2);
			@(posedge aclk);
			check("asleep", sleep_active, 1);
			pwake <= k == 0;
			cwake <= k == 1;
			pin <= k != 2;
			repeat (8) @(posedge aclk);
			pwake <= 1'b0;
			cwake <= 1'b0;
			pin <= 1'b1;
			wait_rst(1'b0);
			rs(exp[k]);
		end
	endtask
	task t_cfg;
		pin <= 1'b0;
		por(1'b0, 1'b0);
		wait_rst(1'b0);
		check("por_gp", n >= POR && n <= POR + 5, 1);
		w(`OFS_OPTIONS, 0);
		repeat (300) @(posedge aclk);
		check("no_wdt", core_reset, 0);
		rs(32'h18);
	endtask
	initial begin
		t_por;
		t_wdt;
		t_sleep;
		t_wake;
		t_cfg;
		test_done;
	end
endmodule // reset_timer_and_watchdog_tb
`default_nettype wire
